// ---- shared/csi_pkg.sv ----
package csi_pkg;

  // Data memory map of the core registers handled here
  localparam logic [6:0] ADDR_INDIRECT = 7'h00;
  localparam logic [6:0] ADDR_POINTER  = 7'h01;
  localparam logic [6:0] ADDR_ACC      = 7'h05;
  localparam logic [6:0] ADDR_FLAGS    = 7'h0A;
  localparam logic [6:0] ADDR_IRQCTL   = 7'h0B;

  // Flag register bit positions
  localparam int FLG_CARRY = 0;
  localparam int FLG_HALF  = 1;
  localparam int FLG_ZERO  = 2;
  localparam int FLG_SOVF  = 3;
  localparam int FLG_HALT  = 4;
  localparam int FLG_WDOG  = 5;

  // Interrupt control bit positions
  localparam int IRQ_GLOBAL = 0;
  localparam int IRQ_EXT_EN = 1;
  localparam int IRQ_TCK_EN = 2;
  localparam int IRQ_EXT_PD = 4;
  localparam int IRQ_TCK_PD = 5;

  // Software write mask for flags, read mask for interrupt control
  localparam logic [7:0] FLAGS_SW_MASK  = 8'h0F;
  localparam logic [7:0] IRQCTL_RD_MASK = 8'h37;

  // Reset values
  localparam logic [7:0] FLAGS_RST  = 8'h00;
  localparam logic [7:0] IRQCTL_RST = 8'h00;
  localparam logic [7:0] ACC_RST    = 8'h00;
  localparam logic [6:0] PTR_RST    = 7'h00;

  // Interrupt vectors and stack depth
  localparam logic [10:0] VEC_EXT     = 11'h004;
  localparam logic [10:0] VEC_TICK    = 11'h008;
  localparam int          STACK_DEPTH = 4;

  // ALU operation selector
  typedef enum logic [3:0] {
    CSI_ALU_NONE = 4'h0,
    CSI_ALU_ADD  = 4'h1,
    CSI_ALU_ADC  = 4'h2,
    CSI_ALU_SUB  = 4'h3,
    CSI_ALU_SBC  = 4'h4,
    CSI_ALU_AND  = 4'h5,
    CSI_ALU_OR   = 4'h6,
    CSI_ALU_XOR  = 4'h7,
    CSI_ALU_RLC  = 4'h8,
    CSI_ALU_RRC  = 4'h9
  } csi_alu_op_t;

  // Data memory access request from the sequencer
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [6:0] addr;
    logic [7:0] wdata;
  } csi_mem_req_t;

  // Operand path for ALU operations
  typedef struct packed {
    csi_alu_op_t op;
    logic [7:0]  operand;
  } csi_alu_req_t;

  // Core events sampled at instruction boundaries
  typedef struct packed {
    logic boundary;
    logic call;
    logic sub_exit_op;
    logic irq_exit_op;
    logic halt_op;
    logic watchdog_clear_op;
  } csi_core_ev_t;

endpackage

// ---- verilog/csi_core.sv ----
// Function
// - Address 00H has no storage; access goes to the memory pointer target.
// - Indirect access via pointer 00H reads 00H and ignores writes.
// - The memory pointer is seven bits wide.
// - Accumulator sits at 05H and is the operand path for moves.
// - Flag register at 0AH holds six flags; bits 6 and 7 read zero.
// - Software writes to flags never touch halt or watchdog flags.
// - Watchdog flag clears on reset, watchdog-clear or halt; sets on timeout.
// - Halt flag clears on reset or watchdog-clear; sets on halt.
// - Carry sets on add carry or subtract no-borrow; used by rotates.
// - Half carry from low nibble on add, no nibble borrow on subtract.
// - Zero flag sets when the result is zero.
// - Overflow sets when carry into top bit differs from carry out.
// - Calls and interrupt entry push only the program counter.
// - Interrupt entry clears global enable; new requests still latch.
// - With the stack full, pending interrupts wait until the stack pops.
// - Falling edge of the external pin sets pending bit 4.
// - External service vectors to 04H, clears its pending and global enable.
// - Timer overflow sets pending bit 5.
// - Timer service vectors to 08H, clears its pending and global enable.
// - Interrupt return sets global enable; subroutine return leaves it.
// - Control bit 0 global, 1 external, 2 timer enable; 3,6,7 read zero.
// - Both interrupt sources wake the device from halt.
// - External request wins over timer when both pend.
// - Pending flags stay set until serviced or cleared by software.
`timescale 1ns/1ps

module csi_core #(
  parameter int DEPTH = csi_pkg::STACK_DEPTH
) (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire csi_pkg::csi_mem_req_t i_mem,
  input  wire csi_pkg::csi_alu_req_t i_alu,
  input  wire csi_pkg::csi_core_ev_t i_ev,
  input  wire logic [7:0]            i_ram_rdata,
  input  wire logic                  i_ext_irq_n,
  input  wire logic                  i_tick_ovf,
  input  wire logic                  i_wdog_timeout,
  output logic [7:0]                 o_rdata,
  output logic                       o_ram_wr,
  output logic [6:0]                 o_ram_addr,
  output logic [7:0]                 o_ram_wdata,
  output logic [7:0]                 o_flags,
  output logic [7:0]                 o_irq_ctl,
  output logic [7:0]                 o_acc,
  output logic [6:0]                 o_memory_pointer,
  output logic                       o_irq_take,
  output logic [10:0]                o_irq_vector,
  output logic                       o_wake,
  output logic                       o_stack_full
);
  import csi_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  // Resolve an address through the indirect port
  // Only address 00H is redirected; a pointer of 00H lands back on the port,
  // which the callers treat as the null case rather than a second hop
  function automatic logic [6:0] eff_addr(input logic [6:0] a, input logic [6:0] ptr);
    eff_addr = (a == ADDR_INDIRECT) ? ptr : a;
  endfunction

  // Full ALU with flag generation; returns {flags[3:0], result}
  // Flags come out as overflow, zero, half carry, carry so that the caller
  // can copy the nibble straight into the flag register
  function automatic logic [11:0] alu_eval(input csi_alu_op_t op,
                                           input logic [7:0] a,
                                           input logic [7:0] b,
                                           input logic c_in);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bb;
    logic       cin;
    logic       c7;
    logic [7:0] res;
    logic       c;
    logic       h;
    logic       v;
    sum = 9'h000;
    nib = 5'h00;
    bb  = b;
    cin = 1'b0;
    c7  = 1'b0;
    res = 8'h00;
    c   = c_in;
    h   = 1'b0;
    v   = 1'b0;
    case (op)
      CSI_ALU_ADD, CSI_ALU_ADC, CSI_ALU_SUB, CSI_ALU_SBC: begin
        // Subtract as add of complement, so carry means no borrow
        bb  = (op == CSI_ALU_SUB || op == CSI_ALU_SBC) ? ~b : b;
        cin = (op == CSI_ALU_SUB) ? 1'b1 :
              (op == CSI_ALU_ADD) ? 1'b0 : c_in;
        sum = {1'b0, a} + {1'b0, bb} + {8'h00, cin};
        nib = {1'b0, a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
        c7  = a[7] ^ bb[7] ^ sum[7];          // Carry into the top bit
        res = sum[7:0];
        c   = sum[8];
        h   = nib[4];
        v   = c7 ^ sum[8];
      end
      CSI_ALU_AND: res = a & b;
      CSI_ALU_OR:  res = a | b;
      CSI_ALU_XOR: res = a ^ b;
      CSI_ALU_RLC: begin
        res = {a[6:0], c_in};
        c   = a[7];
      end
      CSI_ALU_RRC: begin
        res = {c_in, a[7:1]};
        c   = a[0];
      end
      default: res = a;
    endcase
    alu_eval = {v, (res == 8'h00), h, c, res};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0]  flags_reg;
  logic [7:0]  irq_reg;
  logic [7:0]  acc_reg;
  logic [6:0]  ptr_reg;
  logic        ext_pin_reg;
  logic [2:0]  sp_reg;
  logic [11:0] alu_out;
  logic [6:0]  ea;
  logic        ind_null;
  logic        wr_ok;
  logic        stack_full;
  logic        ext_edge;
  logic        take_ext;
  logic        take_tick;
  logic [7:0]  rd_next;

  assign ea         = eff_addr(i_mem.addr, ptr_reg);
  assign ind_null   = (i_mem.addr == ADDR_INDIRECT) && (ptr_reg == ADDR_INDIRECT);
  assign wr_ok      = i_mem.wr && !ind_null;
  assign stack_full = (sp_reg == 3'(DEPTH));
  assign ext_edge   = ext_pin_reg && !i_ext_irq_n;
  assign alu_out    = alu_eval(i_alu.op, acc_reg, i_alu.operand, flags_reg[FLG_CARRY]);

  // Service decision at boundaries only; external has priority
  // Deciding only at boundaries keeps an instruction whole; the cost is up to
  // one instruction of extra latency on a fresh request
  assign take_ext  = i_ev.boundary && !stack_full && irq_reg[IRQ_GLOBAL]
                     && irq_reg[IRQ_EXT_EN] && irq_reg[IRQ_EXT_PD];
  assign take_tick = i_ev.boundary && !stack_full && irq_reg[IRQ_GLOBAL]
                     && irq_reg[IRQ_TCK_EN] && irq_reg[IRQ_TCK_PD]
                     && !take_ext;

  // Pin history for falling edge detection; held high at reset so no false edge
  // The pin is taken as already synchronous; an asynchronous source needs its
  // own synchroniser in front of this port
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_pin_reg <= 1'b1;
    end else begin
      ext_pin_reg <= i_ext_irq_n;
    end
  end

  // Stack pointer: only the return address is pushed, held outside this block
  // A return on an empty stack is ignored, so a stray return cannot wrap the
  // level round to full and block interrupts
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sp_reg <= 3'h0;
    end else if (i_ev.call || take_ext || take_tick) begin
      // A call on a full stack overwrites the oldest entry, level stays full
      if (!stack_full) begin
        sp_reg <= sp_reg + 3'h1;
      end
    end else if ((i_ev.sub_exit_op || i_ev.irq_exit_op) && sp_reg != 3'h0) begin
      sp_reg <= sp_reg - 3'h1;
    end
  end

  // Memory pointer
  // Only seven bits are stored; the top data bit of a write is dropped and
  // reads back as zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr_reg <= PTR_RST;
    end else if (wr_ok && ea == ADDR_POINTER) begin
      ptr_reg <= i_mem.wdata[6:0];
    end
  end

  // Accumulator: ALU result or direct memory write
  // A memory write wins over an ALU result in the same cycle, so a move into
  // the accumulator is never lost to a stray operation
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      acc_reg <= ACC_RST;
    end else if (wr_ok && ea == ADDR_ACC) begin
      acc_reg <= i_mem.wdata;
    end else if (i_alu.op != CSI_ALU_NONE) begin
      acc_reg <= alu_out[7:0];
    end
  end

  // Arithmetic flags: software write, else ALU update
  // Logic operations touch only the zero flag; carry keeps its value so a
  // following add with carry still sees the old carry
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg[3:0] <= FLAGS_RST[3:0];
    end else if (wr_ok && ea == ADDR_FLAGS) begin
      flags_reg[3:0] <= i_mem.wdata[3:0] & FLAGS_SW_MASK[3:0];
    end else if (i_alu.op == CSI_ALU_AND || i_alu.op == CSI_ALU_OR
                 || i_alu.op == CSI_ALU_XOR) begin
      flags_reg[FLG_ZERO] <= alu_out[8 + FLG_ZERO];
    end else if (i_alu.op != CSI_ALU_NONE) begin
      flags_reg[3:0] <= alu_out[11:8];
    end
  end

  // Halt flag: not writable by software
  // The clear wins over halt in one cycle; both are instructions, so the
  // sequencer never issues them together
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg[FLG_HALT] <= 1'b0;
    end else if (i_ev.watchdog_clear_op) begin
      flags_reg[FLG_HALT] <= 1'b0;
    end else if (i_ev.halt_op) begin
      flags_reg[FLG_HALT] <= 1'b1;
    end
  end

  // Watchdog flag: timeout wins over a clear in the same cycle
  // A hardware event must never be lost to a clear, hence the set comes first
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg[FLG_WDOG] <= 1'b0;
    end else if (i_wdog_timeout) begin
      flags_reg[FLG_WDOG] <= 1'b1;
    end else if (i_ev.watchdog_clear_op || i_ev.halt_op) begin
      flags_reg[FLG_WDOG] <= 1'b0;
    end
  end

  // Unused flag bits are constant zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg[7:6] <= 2'h0;
    end else begin
      flags_reg[7:6] <= 2'h0;
    end
  end

  // Interrupt enables; global enable cleared on service, set by interrupt return
  // A service in the same cycle as a software write leaves the global enable
  // low, so the entry always runs with further service blocked
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg[2:0] <= IRQCTL_RST[2:0];
    end else begin
      if (wr_ok && ea == ADDR_IRQCTL) begin
        irq_reg[2:0] <= i_mem.wdata[2:0];
      end
      if (take_ext || take_tick) begin
        irq_reg[IRQ_GLOBAL] <= 1'b0;
      end else if (i_ev.irq_exit_op) begin
        irq_reg[IRQ_GLOBAL] <= 1'b1;
      end
    end
  end

  // External pending: edge set beats software clear and service clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg[IRQ_EXT_PD] <= 1'b0;
    end else if (ext_edge) begin
      irq_reg[IRQ_EXT_PD] <= 1'b1;
    end else if (take_ext) begin
      irq_reg[IRQ_EXT_PD] <= 1'b0;
    end else if (wr_ok && ea == ADDR_IRQCTL) begin
      irq_reg[IRQ_EXT_PD] <= i_mem.wdata[IRQ_EXT_PD];
    end
  end

  // Timer pending: overflow set beats any clear
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg[IRQ_TCK_PD] <= 1'b0;
    end else if (i_tick_ovf) begin
      irq_reg[IRQ_TCK_PD] <= 1'b1;
    end else if (take_tick) begin
      irq_reg[IRQ_TCK_PD] <= 1'b0;
    end else if (wr_ok && ea == ADDR_IRQCTL) begin
      irq_reg[IRQ_TCK_PD] <= i_mem.wdata[IRQ_TCK_PD];
    end
  end

  // Reserved control bits stay zero
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_reg[3] <= 1'b0;
      irq_reg[7:6] <= 2'h0;
    end else begin
      irq_reg[3] <= 1'b0;
      irq_reg[7:6] <= 2'h0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read mux and outputs

  // Core registers answer locally, everything else goes to RAM
  // Other locations below 20H come from the memory side as well
  always_comb begin
    rd_next = i_ram_rdata;
    if (ind_null) begin
      rd_next = 8'h00;
    end else if (ea == ADDR_POINTER) begin
      rd_next = {1'b0, ptr_reg};
    end else if (ea == ADDR_ACC) begin
      rd_next = acc_reg;
    end else if (ea == ADDR_FLAGS) begin
      rd_next = flags_reg;
    end else if (ea == ADDR_IRQCTL) begin
      rd_next = irq_reg & IRQCTL_RD_MASK;
    end
  end

  // Registered outputs; read data is valid one cycle after the request
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata     <= 8'h00;
      o_ram_wr    <= 1'b0;
      o_ram_addr  <= 7'h00;
      o_ram_wdata <= 8'h00;
    end else begin
      o_rdata     <= i_mem.rd ? rd_next : 8'h00;
      // Indirect write through pointer 00H never reaches memory
      o_ram_wr    <= wr_ok;
      o_ram_addr  <= ea;
      o_ram_wdata <= i_mem.wdata;
    end
  end

  // Status mirrors and interrupt call request
  // The mirrors lag the registers by one cycle; consumers that need the
  // newest value must allow for it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flags          <= 8'h00;
      o_irq_ctl        <= 8'h00;
      o_acc            <= 8'h00;
      o_memory_pointer <= 7'h00;
      o_irq_take       <= 1'b0;
      o_irq_vector     <= 11'h000;
      o_wake           <= 1'b0;
      o_stack_full     <= 1'b0;
    end else begin
      o_flags          <= flags_reg;
      o_irq_ctl        <= irq_reg & IRQCTL_RD_MASK;
      o_acc            <= acc_reg;
      o_memory_pointer <= ptr_reg;
      o_irq_take       <= take_ext || take_tick;
      o_irq_vector     <= take_ext ? VEC_EXT : (take_tick ? VEC_TICK : 11'h000);
      // Wake on any enabled pending request, regardless of global enable
      o_wake           <= (irq_reg[IRQ_EXT_EN] && irq_reg[IRQ_EXT_PD])
                          || (irq_reg[IRQ_TCK_EN] && irq_reg[IRQ_TCK_PD]);
      o_stack_full     <= stack_full;
    end
  end

endmodule

// ---- test/csi_core_properties.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module csi_core_properties #(
  parameter int DEPTH = csi_pkg::STACK_DEPTH
) (
  input wire logic                  i_clk,
  input wire logic                  i_rst_n,
  input wire csi_pkg::csi_mem_req_t i_mem,
  input wire csi_pkg::csi_core_ev_t i_ev,
  input wire logic                  i_wdog_timeout,
  input wire logic [7:0]            o_rdata,
  input wire logic                  o_ram_wr,
  input wire logic [6:0]            o_ram_addr,
  input wire logic [7:0]            o_ram_wdata,
  input wire logic [7:0]            o_flags,
  input wire logic [7:0]            o_irq_ctl,
  input wire logic [6:0]            o_memory_pointer,
  input wire logic                  o_irq_take,
  input wire logic [10:0]           o_irq_vector,
  input wire logic                  o_wake,
  input wire logic                  o_stack_full
);
  import csi_pkg::*;

  // Either return kind pops the stack
  logic pop_any;
  assign pop_any = i_ev.sub_exit_op | i_ev.irq_exit_op;

  default clocking dcb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  //////////////////////////////////////////////////////////////////////////////
  // Pointer mirror lags a cycle, so a write just before makes it stale
  AST_IND_RD_ZERO: assert property (
    i_mem.rd && !i_mem.wr && i_mem.addr == ADDR_INDIRECT && o_memory_pointer == 7'h00
    && !$past(i_mem.wr) |=> o_rdata == 8'h00)
    else $error("indirect read via null pointer not zero");
  AST_IND_WR_DROP: assert property (
    i_mem.wr && !i_mem.rd && i_mem.addr == ADDR_INDIRECT && o_memory_pointer == 7'h00
    && !$past(i_mem.wr) |=> !o_ram_wr)
    else $error("indirect write via null pointer reached memory");
  AST_IND_WR_ROUTE: assert property (
    i_mem.wr && !i_mem.rd && i_mem.addr == ADDR_INDIRECT && o_memory_pointer >= 7'h20
    && !$past(i_mem.wr) |=> o_ram_wr && o_ram_addr == $past(o_memory_pointer)
    && o_ram_wdata == $past(i_mem.wdata))
    else $error("indirect write not routed through pointer");

  // Status mirror shows a flag change two edges after its cause
  AST_HALT_SETS: assert property (
    i_ev.halt_op && !i_ev.watchdog_clear_op |=> ##1 o_flags[FLG_HALT])
    else $error("halt flag not set by halt");
  AST_WCLR_CLEARS: assert property (
    i_ev.watchdog_clear_op && !i_ev.halt_op && !i_wdog_timeout
    |=> ##1 !o_flags[FLG_WDOG] && !o_flags[FLG_HALT])
    else $error("watchdog clear left a flag set");

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt acceptance
  AST_TAKE_CAUSE: assert property (
    o_irq_take |-> $past(i_ev.boundary))
    else $error("interrupt taken off a boundary");
  AST_TAKE_MASK: assert property (
    o_irq_take |=> !o_irq_ctl[IRQ_GLOBAL] && !o_irq_take)
    else $error("global enable not cleared on entry");
  AST_TAKE_VEC: assert property (
    o_irq_take |-> (o_irq_vector == VEC_EXT) || (o_irq_vector == VEC_TICK))
    else $error("interrupt vector not 004 or 008");
  AST_FULL_HOLD: assert property (
    i_ev.boundary && o_stack_full && !pop_any && !$past(pop_any) && !$past(pop_any, 2)
    |=> !o_irq_take)
    else $error("interrupt taken with stack full");
  AST_WAKE: assert property (
    o_wake == ((o_irq_ctl[IRQ_EXT_PD] & o_irq_ctl[IRQ_EXT_EN])
    | (o_irq_ctl[IRQ_TCK_PD] & o_irq_ctl[IRQ_TCK_EN])))
    else $error("wake does not follow enabled requests");
  AST_IRQ_EXIT_OP: assert property (
    i_ev.irq_exit_op && !i_mem.wr |=> ##1 o_irq_ctl[IRQ_GLOBAL])
    else $error("interrupt return left global enable low");
  // Mirror and take pulse come from the same register snapshot
  AST_TAKE_PRIO: assert property (
    o_irq_take && o_irq_ctl[IRQ_EXT_PD] && o_irq_ctl[IRQ_EXT_EN] |-> o_irq_vector == VEC_EXT)
    else $error("timer served ahead of a pending external request");
endmodule

bind csi_core csi_core_properties #(.DEPTH(DEPTH)) u_csi_core_properties (
  .i_clk, .i_rst_n, .i_mem, .i_ev, .i_wdog_timeout, .o_rdata, .o_ram_wr, .o_ram_addr,
  .o_ram_wdata, .o_flags, .o_irq_ctl, .o_memory_pointer, .o_irq_take, .o_irq_vector,
  .o_wake, .o_stack_full
);

// ---- test/testbench.sv ----
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module testbench;
  import csi_pkg::*;

  // Event codes: boundary, call, sub exit, irq exit, halt, watchdog clear
  localparam logic [5:0] BND = 6'h20;
  localparam logic [5:0] CAL = 6'h10;
  localparam logic [5:0] SBX = 6'h08;
  localparam logic [5:0] IRX = 6'h04;
  localparam logic [5:0] HLT = 6'h02;
  localparam logic [5:0] WCL = 6'h01;

  logic         clk, rst_n, ext_n, tick, wdto, ram_wr, take, wake, full;
  logic [7:0]   ram_rd, rdata, ram_wdata, flags, irq_ctl, acc;
  logic [6:0]   ram_addr, mptr;
  logic [10:0]  vec;
  logic [15:0]  wv;
  logic [7:0]   m;
  csi_mem_req_t mem;
  csi_alu_req_t alu;
  csi_core_ev_t ev;
  int           fails, compares, cycles, seed, m_acc, m_fl, m_irq, a, b, c, ci, d, r;
  int           stk[$];
  logic [6:0]   ra[4] = '{ADDR_POINTER, ADDR_ACC, ADDR_FLAGS, ADDR_IRQCTL};
  csi_alu_op_t  ops[9] = '{CSI_ALU_ADD, CSI_ALU_ADC, CSI_ALU_SUB, CSI_ALU_SBC, CSI_ALU_AND,
                           CSI_ALU_OR, CSI_ALU_XOR, CSI_ALU_RLC, CSI_ALU_RRC};

  csi_core u_csi_core (
    .i_clk(clk), .i_rst_n(rst_n), .i_mem(mem), .i_alu(alu), .i_ev(ev), .i_ram_rdata(ram_rd),
    .i_ext_irq_n(ext_n), .i_tick_ovf(tick), .i_wdog_timeout(wdto), .o_rdata(rdata),
    .o_ram_wr(ram_wr), .o_ram_addr(ram_addr), .o_ram_wdata(ram_wdata), .o_flags(flags),
    .o_irq_ctl(irq_ctl), .o_acc(acc), .o_memory_pointer(mptr), .o_irq_take(take),
    .o_irq_vector(vec), .o_wake(wake), .o_stack_full(full)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; run needs about five hundred cycles
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic chk(input string n, input logic [15:0] s, input int e);
    compares++;
    if (s !== 16'(e)) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, 16'(e), s);
    end
  endtask

  // Model state restarts with the design; stack is empty after reset
  task automatic rst();
    rst_n = 1'b0;
    cyc(3);
    rst_n = 1'b1;
    m_acc = 0;
    m_fl = 0;
    m_irq = 0;
    stk.delete();
    cyc(1);
  endtask

  // Every bus task idles a cycle after release so strobes never re-assert in one step
  task automatic rc(input string n, input logic [6:0] ad, input int e, input logic [7:0] k = 8'hFF);
    mem = '{1'b1, 1'b0, ad, 8'h00};
    cyc(1);
    mem = '0;
    chk(n, 16'(rdata & k), e & k);
    cyc(1);
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] dt);
    mem = '{1'b0, 1'b1, ad, dt};
    cyc(1);
    mem = '0;
    wv = {ram_wr, ram_addr, ram_wdata};
    case (ad)
      ADDR_ACC:    m_acc = dt;
      ADDR_FLAGS:  m_fl = (m_fl & 8'h30) | (dt & FLAGS_SW_MASK);
      ADDR_IRQCTL: m_irq = dt & IRQCTL_RD_MASK;
      default: ;
    endcase
    cyc(1);
  endtask

  // Event pulse; the take answer is judged on every pulse
  task automatic pe(input logic [5:0] e);
    int x;
    x = 0;
    ev = e;
    cyc(1);
    ev = '0;
    if (e[5] && m_irq[0] && stk.size() < 4) begin
      if (m_irq[4] && m_irq[1]) x = 12'h804;
      else if (m_irq[5] && m_irq[2]) x = 12'h808;
    end
    if (x != 0) begin
      m_irq = m_irq & (x == 12'h804 ? 8'h2E : 8'h1E);
      stk.push_back(x);
    end
    if (e[4] && stk.size() < 4) stk.push_back(0);
    if ((e[3] || e[2]) && stk.size() > 0) void'(stk.pop_back());
    if (e[2]) m_irq = m_irq | 8'h01;
    if (e[1]) m_fl = (m_fl & 8'hDF) | 8'h10;
    if (e[0]) m_fl = m_fl & 8'hCF;
    chk("take", {take, vec}, x);
    cyc(1);
  endtask

  // Source event: 0 pin falling edge, 1 timer overflow, 2 watchdog timeout
  task automatic src(input int k);
    ext_n = (k != 0);
    tick = (k == 1);
    wdto = (k == 2);
    cyc(1);
    {ext_n, tick, wdto} = 3'b100;
    if (k == 2) m_fl = m_fl | 8'h20;
    else m_irq = m_irq | (k == 0 ? 8'h10 : 8'h20);
    cyc(1);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst_n, ext_n, tick, wdto} = 4'h4;
    {mem, alu, ev, ram_rd} = '0;
    {fails, compares, cycles} = '0;
    seed = 9459;
    rst();
    foreach (ra[i]) rc("reset", ra[i], 0);
    // Pointer and indirect port
    wr(ADDR_POINTER, 8'hA5);
    rc("pointer", ADDR_POINTER, 8'h25);
    chk("ptr out", mptr, 8'h25);
    wr(ADDR_POINTER, 8'h00);
    rc("ind zero", ADDR_INDIRECT, 0);
    wr(ADDR_INDIRECT, 8'h5A);
    chk("ind drop", wv[15], 0);
    d = 32 + ($random(seed) & 95);
    wr(ADDR_POINTER, 8'(d));
    ram_rd = 8'($random(seed));
    rc("ind rd", ADDR_INDIRECT, ram_rd);
    wr(ADDR_INDIRECT, 8'h3C);
    chk("ind wr", wv, 16'h8000 | (d << 8) | 16'h003C);
    // ALU ops on random operands, every op four times
    for (int i = 0; i < 36; i++) begin
      wr(ADDR_ACC, 8'($random(seed)));
      wr(ADDR_FLAGS, 8'($random(seed)));
      d = $random(seed) & 255;
      alu = '{ops[i % 9], 8'(d)};
      cyc(1);
      alu = '0;
      cyc(1);
      a = m_acc;
      c = m_fl & 1;
      case (i % 9)
        4, 5, 6: begin
          r = (i % 9 == 4) ? a & d : (i % 9 == 5) ? a | d : a ^ d;
          m_fl = (m_fl & 8'hFB) | ((r == 0) * 4);
          m = 8'h04;
        end
        7, 8: begin
          r = (i % 9 == 7) ? (a * 2 + c) % 256 : a / 2 + c * 128;
          m_fl = (m_fl & 8'hFE) | ((i % 9 == 7) ? a / 128 : a % 2);
          m = 8'h01;
        end
        default: begin
          b = (i % 9 >= 2) ? 255 - d : d;
          ci = (i % 9 == 0) ? 0 : (i % 9 == 2) ? 1 : c;
          r = a + b + ci;
          m_fl = (m_fl & 8'h30) | (r / 256) | ((a % 16 + b % 16 + ci) / 16 * 2)
                 | ((r % 256 == 0) * 4) | ((((a % 128 + b % 128 + ci) / 128) ^ (r / 256)) * 8);
          m = 8'h0F;
        end
      endcase
      m_acc = r % 256;
      rc("acc", ADDR_ACC, m_acc);
      chk("acc out", acc, m_acc);
      rc("alu flags", ADDR_FLAGS, m_fl, m);
    end
    // Halt and watchdog flags against software writes
    rst();
    pe(HLT);
    rc("flags", ADDR_FLAGS, m_fl);
    wr(ADDR_FLAGS, 8'hFF);
    rc("flags", ADDR_FLAGS, m_fl);
    src(2);
    rc("flags", ADDR_FLAGS, m_fl);
    pe(WCL);
    rc("flags", ADDR_FLAGS, m_fl);
    src(2);
    pe(HLT);
    wr(ADDR_FLAGS, 8'h00);
    rc("flags", ADDR_FLAGS, m_fl);
    // Interrupt control, entry, priority and return
    rst();
    wr(ADDR_IRQCTL, 8'hFF);
    rc("irq", ADDR_IRQCTL, m_irq);
    wr(ADDR_IRQCTL, 8'h07);
    rc("irq", ADDR_IRQCTL, m_irq);
    pe(CAL);
    src(0);
    rc("irq", ADDR_IRQCTL, m_irq);
    chk("wake", wake, 1);
    repeat (5) begin
      cyc(1);
      chk("idle", take, 0);
    end
    pe(BND);
    rc("irq", ADDR_IRQCTL, m_irq);
    src(1);
    pe(BND);
    rc("irq", ADDR_IRQCTL, m_irq);
    pe(SBX);
    rc("irq", ADDR_IRQCTL, m_irq);
    src(0);
    pe(IRX);
    rc("irq", ADDR_IRQCTL, m_irq);
    pe(BND);
    pe(IRX);
    pe(BND);
    rc("irq", ADDR_IRQCTL, m_irq);
    // Full stack holds back a pending timer request
    rst();
    wr(ADDR_IRQCTL, 8'h05);
    repeat (4) pe(CAL);
    cyc(2);
    chk("full", full, 1);
    src(1);
    pe(BND);
    pe(SBX);
    cyc(2);
    chk("full", full, 0);
    pe(BND);
    report_and_stop();
  end
endmodule
